// ==== par_ctrl.sv ====
// Parallel I/O controller: APB register file, pad muxing, change interrupt.
// Assumes peripheral signals share pclk; pad inputs are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module par_ctrl
    import par_pkg::*;
#(
    parameter logic [31:0] LINE_MASK = PAR_LINES_A,
    parameter logic [31:0] MUX_MASK = PAR_MUXED_A
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PAR_AW-1:0] paddr,
    input wire logic [PAR_DW-1:0] pwdata,
    output logic [PAR_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pads
    input wire logic [31:0] pad_in,
    output logic [31:0] pad_out,
    output logic [31:0] pad_oe,
    // Shared peripherals
    input wire logic [31:0] periph_out,
    input wire logic [31:0] periph_oe,
    output logic [31:0] periph_in,
    // Interrupt to the interrupt controller
    output logic port_change_irq
);

    par_state_type st_q;
    par_state_type st_d;
    logic [31:0] level_w;

    // Per-line synchroniser and filter, implemented lines only
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_line
            if (LINE_MASK[gi]) begin : g_impl
                par_in_filter u_filt (
                    .pclk(pclk),
                    .presetn(presetn),
                    .pad_in(pad_in[gi]),
                    .filt_en(st_q.flt[gi]), // R14
                    .level(level_w[gi])
                );
            end else begin : g_none
                assign level_w[gi] = 1'b0; // R20
            end
        end
    endgenerate

    logic setup_w;
    logic wr_w;
    logic rd_w;
    logic [31:0] wd_w;
    logic [31:0] change_w;
    logic [31:0] rdsel_w;
    logic mapped_w;

    always_comb begin
        st_d = st_q;
        setup_w = psel && !penable;
        wr_w = psel && penable && st_q.pready && pwrite;
        rd_w = psel && penable && st_q.pready && !pwrite;
        wd_w = pwdata & LINE_MASK; // R20

        // Register writes take effect at the access edge
        if (wr_w) begin
            unique case (paddr)
                PAR_OFS_OWN_SET: st_d.own = st_q.own | (wd_w & MUX_MASK); // R22 R6
                PAR_OFS_OWN_CLR: st_d.own = st_q.own & ~(wd_w & MUX_MASK); // R22 R6 R2
                PAR_OFS_OE_SET: st_d.oe = st_q.oe | wd_w; // R8 R5
                PAR_OFS_OE_CLR: st_d.oe = st_q.oe & ~wd_w; // R8
                PAR_OFS_FLT_SET: st_d.flt = st_q.flt | wd_w; // R14
                PAR_OFS_FLT_CLR: st_d.flt = st_q.flt & ~wd_w; // R14
                PAR_OFS_LVL_SET: st_d.lvl_out = st_q.lvl_out | wd_w; // R10
                PAR_OFS_LVL_CLR: st_d.lvl_out = st_q.lvl_out & ~wd_w; // R10
                PAR_OFS_IRQ_EN: st_d.msk = st_q.msk | wd_w; // R15
                PAR_OFS_IRQ_DIS: st_d.msk = st_q.msk & ~wd_w; // R15
                default: ;
            endcase
        end

        // Change detection against last cycle's level
        change_w = (level_w ^ st_q.lvl_prev) & LINE_MASK; // R24 R16
        st_d.lvl_prev = level_w;

        // Clear only bits already returned; new changes win
        if (rd_w && (paddr == PAR_OFS_IRQ_STS)) begin
            st_d.sts = (st_q.sts & ~st_q.prdata) | change_w; // R18
        end else begin
            st_d.sts = st_q.sts | change_w; // R16
        end

        // Pad muxing
        st_d.pad_oe = (st_q.own & st_q.oe) | (~st_q.own & periph_oe & LINE_MASK); // R9 R11 R12
        st_d.pad_out = (st_q.own & st_q.lvl_out) | (~st_q.own & periph_out & LINE_MASK); // R10 R12
        st_d.periph_in = ~st_q.own & level_w & LINE_MASK; // R7

        st_d.irq = |(st_d.sts & st_d.msk); // R17 R3

        // Read data and answer prepared in the setup cycle
        rdsel_w = 32'h00000000;
        mapped_w = 1'b1;
        unique case (paddr)
            PAR_OFS_OWN_STS: rdsel_w = st_q.own | (~MUX_MASK & LINE_MASK); // R2 R23 R6
            PAR_OFS_OE_STS: rdsel_w = st_q.oe; // R8
            PAR_OFS_FLT_STS: rdsel_w = st_q.flt; // R14
            PAR_OFS_LVL_STS: rdsel_w = st_q.lvl_out; // R10
            PAR_OFS_PAD_STS: rdsel_w = level_w; // R13
            PAR_OFS_IRQ_MSK: rdsel_w = st_q.msk; // R15
            PAR_OFS_IRQ_STS: rdsel_w = st_q.sts | change_w; // R18
            PAR_OFS_OWN_SET, PAR_OFS_OWN_CLR, PAR_OFS_OE_SET, PAR_OFS_OE_CLR,
            PAR_OFS_FLT_SET, PAR_OFS_FLT_CLR, PAR_OFS_LVL_SET, PAR_OFS_LVL_CLR,
            PAR_OFS_IRQ_EN, PAR_OFS_IRQ_DIS: rdsel_w = 32'h00000000;
            default: mapped_w = 1'b0;
        endcase
        st_d.pready = setup_w;
        if (setup_w) begin
            st_d.prdata = pwrite ? 32'h00000000 : (rdsel_w & LINE_MASK); // R19 R20
            st_d.pslverr = !mapped_w;
        end
        if (rd_w && (paddr == PAR_OFS_IRQ_STS)) begin
            // Returned value stays visible; returned status bits clear at this same edge
            st_d.prdata = st_q.prdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
            st_q.own <= PAR_RST_OWN & LINE_MASK; // R4 R21 R1
            st_q.oe <= PAR_RST_ZERO; // R4
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata = st_q.prdata;
    assign pready = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign pad_out = st_q.pad_out;
    assign pad_oe = st_q.pad_oe;
    assign periph_in = st_q.periph_in;
    assign port_change_irq = st_q.irq;

endmodule // par_ctrl
`default_nettype wire

// ==== par_pkg.sv ====
// Constants, register map and state types of the parallel I/O controller.
// Assumes one 50 MHz APB clock domain; pad levels arrive asynchronously.
//
// Contract
// R1: 23 lines over two identical controller instances
// R2: Dedicated pins ignore owner writes, read owned
// R3: Each instance drives its own interrupt request
// R4: Reset: controller owns pins, drivers off
// R5: Owned lines usable in both directions
// R6: Owner set/clear registers, owner status readback
// R7: Peripheral input forced zero while controller owns
// R8: Output enable set/clear, direction status readback
// R9: Direction applies only under controller ownership
// R10: Level set/clear registers, level status readback
// R11: Owned, output disabled: pad not driven
// R12: Peripheral owner drives pad value and enable
// R13: Pad level status returns actual pad level
// R14: Glitch filter enable/disable/status, either owner
// R15: Irq enable sets, disable clears mask bits
// R16: Any pad level change sets status bit
// R17: Interrupt asserted on status and mask bit
// R18: Status read returns contents then clears
// R19: All registers 32 bits, same bit per line
// R20: Unimplemented bits ignore writes, read zero
// R21: Instance A implements bits 0 to 12
// R22: Write 1 sets/clears owner, 0 ignored
// R23: Owner status 1 controller, 0 peripheral
// R24: Change found against previous cycle level
// R25: Filter drops pulses under one clock period
package par_pkg;

    localparam int PAR_DW = 32;
    localparam int PAR_AW = 8;

    // Register byte offsets
    localparam logic [7:0] PAR_OFS_OWN_SET = 8'h00;
    localparam logic [7:0] PAR_OFS_OWN_CLR = 8'h04;
    localparam logic [7:0] PAR_OFS_OWN_STS = 8'h08;
    localparam logic [7:0] PAR_OFS_OE_SET = 8'h10;
    localparam logic [7:0] PAR_OFS_OE_CLR = 8'h14;
    localparam logic [7:0] PAR_OFS_OE_STS = 8'h18;
    localparam logic [7:0] PAR_OFS_FLT_SET = 8'h20;
    localparam logic [7:0] PAR_OFS_FLT_CLR = 8'h24;
    localparam logic [7:0] PAR_OFS_FLT_STS = 8'h28;
    localparam logic [7:0] PAR_OFS_LVL_SET = 8'h30;
    localparam logic [7:0] PAR_OFS_LVL_CLR = 8'h34;
    localparam logic [7:0] PAR_OFS_LVL_STS = 8'h38;
    localparam logic [7:0] PAR_OFS_PAD_STS = 8'h3c;
    localparam logic [7:0] PAR_OFS_IRQ_EN = 8'h40;
    localparam logic [7:0] PAR_OFS_IRQ_DIS = 8'h44;
    localparam logic [7:0] PAR_OFS_IRQ_MSK = 8'h48;
    localparam logic [7:0] PAR_OFS_IRQ_STS = 8'h4c;

    // Instance A defaults: bits 0..12, all multiplexed
    localparam logic [31:0] PAR_LINES_A = 32'h00001fff;
    localparam logic [31:0] PAR_MUXED_A = 32'h00001fff;

    // Reset values
    localparam logic [31:0] PAR_RST_OWN = 32'hffffffff;
    localparam logic [31:0] PAR_RST_ZERO = 32'h00000000;

    typedef struct packed {
        logic [31:0] own;
        logic [31:0] oe;
        logic [31:0] lvl_out;
        logic [31:0] flt;
        logic [31:0] msk;
        logic [31:0] sts;
        logic [31:0] lvl_prev;
        logic [31:0] pad_out;
        logic [31:0] pad_oe;
        logic [31:0] periph_in;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
    } par_state_type;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } par_filt_type;

endpackage

// ==== par_in_filter.sv ====
// One pad input: two-stage synchroniser and optional glitch filter.
// Assumes pad_in is asynchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module par_in_filter
    import par_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Pad and control
    input wire logic pad_in,
    input wire logic filt_en,
    output logic level
);

    par_filt_type st_q;
    par_filt_type st_d;

    always_comb begin
        st_d = st_q;
        st_d.s1 = pad_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        // With the filter on, filtered level moves only after two equal samples; off, it follows s2
        if (!filt_en || (st_q.s2 == st_q.s3)) begin // R25
            st_d.lvl = st_q.s2;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign level = st_q.lvl;

endmodule // par_in_filter
`default_nettype wire

// ==== par_pad_model.sv ====
// Pad-side model: the external circuit on each pad.
// Assumes a pull-up on any pad that nobody drives.
`timescale 1ns/1ps
`default_nettype none
module par_pad_model (
    // Controller side
    input wire logic [31:0] pad_out,
    input wire logic [31:0] pad_oe,
    // External drivers
    input wire logic [31:0] ext_val,
    input wire logic [31:0] ext_oe,
    output logic [31:0] pad_in
);
    // Controller drive first, then the outside circuit, then the pull-up
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_oe & ext_val) | (~pad_oe & ~ext_oe);
endmodule // par_pad_model
`default_nettype wire

// ==== par_ctrl_monitor.sv ====
// Port checker for par_ctrl.
// Assumes one pclk domain and an async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module par_ctrl_monitor
    import par_pkg::*;
#(parameter logic [31:0] LINE_MASK = PAR_LINES_A) (
    // Clock, reset, APB
    input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic [PAR_AW-1:0] paddr,
    input wire logic [PAR_DW-1:0] pwdata, prdata,
    // Pads, peripheral, interrupt
    input wire logic [31:0] pad_oe, periph_in,
    input wire logic port_change_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup; psel && !penable; endsequence
    sequence s_rd; psel && penable && pready && !pwrite; endsequence
    a_ready_pulse: assert property (s_setup |=> pready ##1 !pready)
        else $error("pready not a pulse");
    a_hole_err: assert property (psel && !penable && paddr == 8'h0c |=> pslverr)
        else $error("hole not refused");
    a_wo_zero: assert property (s_rd ##0 paddr == PAR_OFS_OWN_SET |-> prdata == 0)
        else $error("write-only read nonzero");
    a_rd_unused: assert property (s_rd |-> (prdata & ~LINE_MASK) == 0)
        else $error("unused bits read");
    a_oe_unused: assert property ((pad_oe & ~LINE_MASK) == 0)
        else $error("unused pad driven");
    a_in_unused: assert property ((periph_in & ~LINE_MASK) == 0)
        else $error("unused input set");
    a_reset_input: assert property ($rose(presetn) |-> (pad_oe == 0) [*3])
        else $error("pad driven after reset");
    a_irq_off: assert property (s_setup ##1 pwrite && paddr == PAR_OFS_IRQ_DIS && pwdata == '1 |-> ##[1:3] !port_change_irq)
        else $error("irq not masked");
endmodule // par_ctrl_monitor
bind par_ctrl par_ctrl_monitor #(.LINE_MASK(LINE_MASK)) u_par_ctrl_monitor (.pclk, .presetn, .psel, .penable,
    .pwrite, .pready, .pslverr, .paddr, .pwdata, .prdata, .pad_oe, .periph_in, .port_change_irq);
`default_nettype wire

// ==== testbench.sv ====
// Bench for par_ctrl: APB master, pad model, random stimulus.
// Assumes zero-wait APB answers.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import par_pkg::*;
    localparam logic [31:0] M = PAR_LINES_A;
    // Second controller: ten lines, bits 3, 4 and 9 dedicated
    localparam logic [31:0] MB = 32'h000003ff, XB = 32'h000001e7;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, port_change_irq, err;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, pad_in, pad_out, pad_oe, periph_out = 0, periph_oe = 0, periph_in;
    logic [31:0] ext_val = 0, ext_oe = '1, rd, r, q, oe_e = 0, lv_e = 0, fl_e = 0, rd_b, prdata_b;
    int n_fail = 0, n_checks = 0, seed = 32'h59d7c672;
    par_ctrl u_par_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .pad_in, .pad_out, .pad_oe, .periph_out, .periph_oe, .periph_in, .port_change_irq);
    par_pad_model u_par_pad_model (.pad_out, .pad_oe, .ext_val, .ext_oe, .pad_in);
    // Shares the bus and pads; only its read data is compared
    par_ctrl #(.LINE_MASK(MB), .MUX_MASK(XB)) u_par_ctrl_b (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata(prdata_b), .pready(), .pslverr(), .pad_in, .pad_out(), .pad_oe(), .periph_out,
        .periph_oe, .periph_in(), .port_change_irq());
    initial forever #10 pclk = ~pclk;
    function automatic logic [31:0] upd(logic [31:0] c, logic [31:0] v, bit clr);
        return clr ? c & ~v : c | v;
    endfunction
    task automatic summarize;
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(logic [31:0] s, logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
        end
    endtask
    task automatic wt(int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        int k = 0;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k == 20) n_fail++;
        rd = prdata;
        rd_b = prdata_b;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic rdc(logic [7:0] a, logic [31:0] e);
        apb(0, a, 0);
        chk(rd, e);
    endtask
    initial begin
        #200000;
        n_fail++;
        summarize();
    end
    initial begin
        wt(8);
        presetn <= 1;
        wt(6);
        rdc(PAR_OFS_OWN_STS, M);
        chk(rd_b, MB);
        rdc(PAR_OFS_OE_STS, 0);
        rdc(PAR_OFS_IRQ_STS, 0);
        apb(0, 8'h0c, 0);
        chk({31'h0, err}, 32'h1);
        rdc(PAR_OFS_OWN_SET, 0);
        r = $random(seed);
        apb(1, PAR_OFS_OWN_CLR, r);
        apb(1, PAR_OFS_OWN_SET, 0);
        rdc(PAR_OFS_OWN_STS, M & ~r);
        chk(rd_b, MB & ~(r & XB));
        apb(1, PAR_OFS_OWN_CLR, '1);
        r = $random(seed);
        q = $random(seed);
        periph_oe <= r;
        periph_out <= q;
        ext_val <= q;
        wt(8);
        chk(pad_oe, r & M);
        chk(pad_out & r, q & r & M);
        chk(periph_in, q & M);
        apb(1, PAR_OFS_OWN_SET, '1);
        wt(3);
        chk(periph_in, 0);
        chk(pad_oe, 0);
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            q = $random(seed);
            apb(1, i[0] ? PAR_OFS_OE_CLR : PAR_OFS_OE_SET, r);
            apb(1, i[1] ? PAR_OFS_LVL_CLR : PAR_OFS_LVL_SET, q);
            apb(1, i[2] ? PAR_OFS_FLT_CLR : PAR_OFS_FLT_SET, r ^ q);
            oe_e = upd(oe_e, r, i[0]);
            lv_e = upd(lv_e, q, i[1]);
            fl_e = upd(fl_e, r ^ q, i[2]);
            ext_val <= $random(seed);
            wt(8);
            rdc(PAR_OFS_OE_STS, oe_e & M);
            rdc(PAR_OFS_LVL_STS, lv_e & M);
            rdc(PAR_OFS_FLT_STS, fl_e & M);
            chk(pad_oe, oe_e & M);
            rdc(PAR_OFS_PAD_STS, M & (oe_e & lv_e | ~oe_e & ext_val));
        end
        apb(1, PAR_OFS_OE_CLR, '1);
        ext_val <= 0;
        wt(8);
        apb(0, PAR_OFS_IRQ_STS, 0);
        apb(1, PAR_OFS_IRQ_EN, 32'h8);
        rdc(PAR_OFS_IRQ_MSK, 32'h8);
        ext_val <= 32'h18;
        wt(8);
        chk({31'h0, port_change_irq}, 32'h1);
        rdc(PAR_OFS_IRQ_STS, 32'h18);
        chk({31'h0, port_change_irq}, 32'h0);
        rdc(PAR_OFS_IRQ_STS, 0);
        ext_val <= 32'h8;
        wt(8);
        chk({31'h0, port_change_irq}, 32'h0);
        apb(1, PAR_OFS_IRQ_EN, 32'h10);
        chk({31'h0, port_change_irq}, 32'h1);
        apb(1, PAR_OFS_IRQ_DIS, '1);
        chk({31'h0, port_change_irq}, 32'h0);
        // One-cycle pad pulse: dropped with filter on, logged with it off
        apb(1, PAR_OFS_FLT_SET, 32'h4);
        apb(0, PAR_OFS_IRQ_STS, 0);
        for (int f = 0; f < 2; f++) begin
            ext_val <= 32'hc;
            wt(1);
            ext_val <= 32'h8;
            wt(8);
            rdc(PAR_OFS_IRQ_STS, f ? 32'h4 : 32'h0);
            apb(1, PAR_OFS_FLT_CLR, 32'h4);
        end
        // Change on a controller-driven output line
        apb(1, PAR_OFS_LVL_SET, 32'h1);
        apb(1, PAR_OFS_OE_SET, 32'h1);
        wt(8);
        rdc(PAR_OFS_IRQ_STS, 32'h1);
        summarize();
    end
endmodule // testbench
`default_nettype wire
